/* File: core/ccr_pkg.sv */
// Purpose: constants, types and carriers for the CAN control/command register block
// Assumes: APB slave with 32-bit data, registers at index*4
// Notes:   one clock; the internal divided-by-two clock is a phase flag
// Behaviour
// - command address always reads all ones
// - bus-off raises error interrupt when enabled
// - entering reset mode rewinds receive fifo write pointer
// - transmitted message copied, no receive interrupt
// - hardware reset puts both pointers at zero
// - reset request rewinds write pointer to fifo start
// - control register at address zero, read/write
// - overrun enable gates overrun interrupt
// - error enable gates error/bus status changes
// - transmit enable gates transmit-done or buffer-free
// - receive enable gates error-free receive interrupt
// - reset request aborts transfer, clearing resumes
// - bit six stored, survives every reset
// - bit five always reads one
// - hardware reset and bus-off force reset request
// - written reset request changes on internal clock edge
// - held reset ignores clears; host reads back
// - normal exit waits one bus-free period
// - bus-off exit waits 128 bus-free periods
// - command register is write-only, triggers actions
// - command bits: send, cancel, release, clear, sleep

package ccr_pkg;

  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [7:0]  IDX_CTRL   = 8'h00;
  localparam logic [7:0]  IDX_CMD    = 8'h01;
  localparam logic [7:0]  IDX_STATE  = 8'h10;
  localparam logic [11:0] ADDR_CTRL  = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_CMD   = {2'h0, IDX_CMD, 2'h0};
  localparam logic [11:0] ADDR_STATE = {2'h0, IDX_STATE, 2'h0};
  localparam logic [31:0] CMD_READ   = 32'h000000FF;

  // -------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------
  localparam int CTL_REQ    = 0;
  localparam int CTL_RX_EN  = 1;
  localparam int CTL_TX_EN  = 2;
  localparam int CTL_ERR_EN = 3;
  localparam int CTL_OVR_EN = 4;
  localparam int CTL_ONE  = 5;
  localparam int CTL_FREE = 6;
  localparam int CTL_ZERO = 7;
  localparam int CMD_SEND = 0;
  localparam int CMD_CAN  = 1;
  localparam int CMD_REL  = 2;
  localparam int CMD_CLR  = 3;
  localparam int CMD_SLP  = 4;
  localparam logic [3:0]  IE_RESET = 4'h0;

  // -------------------------------------------------------------
  // bus-free timing and fifo
  // -------------------------------------------------------------
  localparam logic [3:0]  FREE_BITS   = 4'hB;
  localparam logic [7:0]  FREE_BUSOFF = 8'h80;
  localparam logic [7:0]  FREE_NORMAL = 8'h01;
  localparam int          PTR_W       = 6;
  localparam logic [5:0]  PTR_ZERO    = 6'h00;

  typedef enum {ST_RESET, ST_WAIT_FREE, ST_BUS_ON} ccr_mode_t;

  typedef struct packed {
    logic bus_off;
    logic err_status;
    logic overrun;
    logic tx_done;
    logic tx_buf_free;
    logic rx_ok;
    logic tx_copy;
  } ccr_evt_t;

  typedef struct packed {
    logic send_request;
    logic cancel_send;
    logic release_rx_slot;
    logic clear_overrun;
    logic sleep_command;
  } ccr_cmd_t;

  typedef struct packed {
    logic rx;
    logic tx;
    logic err;
    logic ovr;
  } ccr_irq_t;

endpackage : ccr_pkg

/* File: core/ccr_busfree.sv */
// Purpose: detects bus-free periods of consecutive recessive bits
// Assumes: bit_tick is a one-cycle pulse per CAN bit, bus_level high is recessive
// Notes:   counting restarts whenever arm drops
`timescale 1ns/1ps

module ccr_busfree
(
  input  logic pclk,
  input  logic presetn,
  input  logic arm,
  input  logic bit_tick,
  input  logic bus_level,
  output logic free_pulse
);

  logic [3:0] cnt_r;
  wire        last = (cnt_r == 4'(ccr_pkg::FREE_BITS - 4'h1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r      <= 4'h0;
      free_pulse <= 1'h0;
    end
    else
    begin
      free_pulse <= arm & bit_tick & bus_level & last;
      if (!arm || (bit_tick && !bus_level) || (bit_tick && last))
        cnt_r <= 4'h0;
      else if (bit_tick)
        cnt_r <= 4'(cnt_r + 4'h1);
    end
  end

endmodule : ccr_busfree

/* File: core/ccr_rxptr.sv */
// Purpose: receive fifo read and write pointers
// Assumes: len is the length of the message being released or stored
// Notes:   rewind wins over advance in the same cycle
`timescale 1ns/1ps

module ccr_rxptr
(
  input  logic                       pclk,
  input  logic                       presetn,
  input  logic                       rewind,
  input  logic                       rel,
  input  logic                       adv,
  input  logic [ccr_pkg::PTR_W-1:0]  len,
  output logic [ccr_pkg::PTR_W-1:0]  rd_ptr,
  output logic [ccr_pkg::PTR_W-1:0]  wr_ptr
);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_ptr <= ccr_pkg::PTR_ZERO;
      wr_ptr <= ccr_pkg::PTR_ZERO;
    end
    else if (rewind)
    begin
      // the read pointer is the valid fifo start; stale data stays behind it
      wr_ptr <= rd_ptr;
    end
    else
    begin
      if (rel)
        rd_ptr <= PTR_ADD(rd_ptr, len);
      if (adv)
        wr_ptr <= PTR_ADD(wr_ptr, len);
    end
  end

  function automatic logic [ccr_pkg::PTR_W-1:0] PTR_ADD(input logic [ccr_pkg::PTR_W-1:0] a,
                                                        input logic [ccr_pkg::PTR_W-1:0] b);
    PTR_ADD = ccr_pkg::PTR_W'(a + b);
  endfunction : PTR_ADD

endmodule : ccr_rxptr

/* File: core/ccr_ctrl.sv */
// Purpose: control and command registers of a CAN controller, reached over APB
// Assumes: event inputs synchronous to pclk, each event a one-cycle pulse, flags levels
// Notes:   one wait state on every APB access; a written reset request follows a divide-by-two phase
`timescale 1ns/1ps

module ccr_ctrl
(
  input  logic                       pclk,
  input  logic                       presetn,
  input  logic                       psel,
  input  logic                       penable,
  input  logic                       pwrite,
  input  logic [11:0]                paddr,
  input  logic [31:0]                pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  ccr_pkg::ccr_evt_t          evt,
  input  logic [ccr_pkg::PTR_W-1:0]  msg_len,
  input  logic                       bit_tick,
  input  logic                       bus_level,
  output ccr_pkg::ccr_cmd_t          cmd,
  output ccr_pkg::ccr_irq_t          irq,
  output logic                       reset_mode,
  output logic                       abort_xfer,
  output logic                       bus_on,
  output logic                       rx_win_tx,
  output logic [ccr_pkg::PTR_W-1:0]  rd_ptr,
  output logic [ccr_pkg::PTR_W-1:0]  wr_ptr
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic               reset_request_r;
  logic               reset_request_nxt;
  logic               phase_r;
  logic               pend_r;
  logic               pend_val_r;
  logic               cause_busoff_r;
  logic [3:0]         ie_r;
  logic               bit6_r;
  logic               bit7_r;
  logic               sleep_r;
  logic [7:0]         free_cnt_r;
  logic               err_prev_r;
  logic               bo_prev_r;
  logic               ovr_prev_r;
  ccr_pkg::ccr_mode_t state_r;
  ccr_pkg::ccr_mode_t state_nxt;
  logic               free_pulse;

  // -------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------
  wire acc       = psel & penable;
  wire done      = acc & pready;
  wire sel_ctrl  = (paddr == ccr_pkg::ADDR_CTRL);
  wire sel_cmd   = (paddr == ccr_pkg::ADDR_CMD);
  wire sel_state = (paddr == ccr_pkg::ADDR_STATE);
  wire mapped    = sel_ctrl | sel_cmd | sel_state;
  wire wr_ctrl   = done & pwrite & sel_ctrl;
  wire wr_cmd    = done & pwrite & sel_cmd;

  wire [7:0] ctrl_view = {bit7_r, bit6_r, 1'h1, ie_r, reset_request_r};

  wire [31:0] state_view = {10'h000, wr_ptr, 2'h0, rd_ptr, 3'h0, sleep_r, rx_win_tx,
                            cause_busoff_r, state_r == ccr_pkg::ST_WAIT_FREE, bus_on};

  wire [31:0] rd_mux;
  assign rd_mux = sel_ctrl ? {24'h000000, ctrl_view} :
                  sel_cmd  ? ccr_pkg::CMD_READ :
                  sel_state ? state_view : 32'h00000000;

  // -------------------------------------------------------------
  // apb answer: one wait cycle so prdata comes from a register
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      if (acc && !pready)
        prdata <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  // -------------------------------------------------------------
  // control register fields
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ie_r   <= ccr_pkg::IE_RESET;
      bit7_r <= 1'h0;
    end
    else if (wr_ctrl)
    begin
      ie_r   <= pwdata[ccr_pkg::CTL_OVR_EN:ccr_pkg::CTL_RX_EN];
      bit7_r <= pwdata[ccr_pkg::CTL_ZERO];
    end
  end

  // no reset on purpose: this bit keeps its value through every reset
  always_ff @(posedge pclk)
  begin
    if (wr_ctrl)
      bit6_r <= pwdata[ccr_pkg::CTL_FREE];
  end

  // -------------------------------------------------------------
  // reset request and internal divided clock
  // -------------------------------------------------------------
  wire int_edge = phase_r;

  always_comb
  begin
    reset_request_nxt = reset_request_r;
    if (evt.bus_off)
      reset_request_nxt = 1'h1;
    else if (pend_r && int_edge)
      reset_request_nxt = pend_val_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_r         <= 1'h0;
      pend_r          <= 1'h0;
      pend_val_r      <= 1'h0;
      reset_request_r <= 1'h1;
      cause_busoff_r  <= 1'h0;
    end
    else
    begin
      phase_r         <= ~phase_r;
      reset_request_r <= reset_request_nxt;
      if (wr_ctrl)
      begin
        pend_r     <= 1'h1;
        pend_val_r <= pwdata[ccr_pkg::CTL_REQ];
      end
      else if (int_edge)
        pend_r <= 1'h0;
      // the cause picks how many bus-free periods the exit must wait
      if (evt.bus_off && !reset_request_r)
        cause_busoff_r <= 1'h1;
      else if (pend_r && int_edge && pend_val_r && !reset_request_r)
        cause_busoff_r <= 1'h0;
    end
  end

  // -------------------------------------------------------------
  // mode sequencing
  // -------------------------------------------------------------
  wire [7:0] need = cause_busoff_r ? ccr_pkg::FREE_BUSOFF : ccr_pkg::FREE_NORMAL;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ccr_pkg::ST_RESET:
        if (!reset_request_r)
          state_nxt = ccr_pkg::ST_WAIT_FREE;
      ccr_pkg::ST_WAIT_FREE:
        if (reset_request_r)
          state_nxt = ccr_pkg::ST_RESET;
        else if (free_pulse && (8'(free_cnt_r + 8'h01) == need))
          state_nxt = ccr_pkg::ST_BUS_ON;
      default:
        if (reset_request_r)
          state_nxt = ccr_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r    <= ccr_pkg::ST_RESET;
      free_cnt_r <= 8'h00;
      bus_on     <= 1'h0;
    end
    else
    begin
      state_r <= state_nxt;
      bus_on  <= (state_nxt == ccr_pkg::ST_BUS_ON);
      if (state_r != ccr_pkg::ST_WAIT_FREE)
        free_cnt_r <= 8'h00;
      else if (free_pulse)
        free_cnt_r <= 8'(free_cnt_r + 8'h01);
    end
  end

  ccr_busfree u_busfree
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .arm        (state_r == ccr_pkg::ST_WAIT_FREE),
    .bit_tick   (bit_tick),
    .bus_level  (bus_level),
    .free_pulse (free_pulse)
  );

  // -------------------------------------------------------------
  // abort, receive window and pointers
  // -------------------------------------------------------------
  wire req_rise = reset_request_nxt & ~reset_request_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_mode <= 1'h1;
      abort_xfer <= 1'h0;
      rx_win_tx  <= 1'h0;
    end
    else
    begin
      reset_mode <= reset_request_nxt;
      abort_xfer <= req_rise;
      // a transmitted copy sits in the window until the next message overwrites it
      if (evt.rx_ok)
        rx_win_tx <= 1'h0;
      else if (evt.tx_copy)
        rx_win_tx <= 1'h1;
    end
  end

  // tx copies never advance the write pointer, so the area is not locked
  ccr_rxptr u_rxptr
  (
    .pclk    (pclk),
    .presetn (presetn),
    .rewind  (req_rise),
    .rel     (cmd.release_rx_slot),
    .adv     (evt.rx_ok),
    .len     (msg_len),
    .rd_ptr  (rd_ptr),
    .wr_ptr  (wr_ptr)
  );

  // -------------------------------------------------------------
  // command decode
  // -------------------------------------------------------------
  wire cmd_live = wr_cmd & ~reset_request_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd     <= '{default: 1'h0};
      sleep_r <= 1'h0;
    end
    else
    begin
      cmd.send_request    <= cmd_live & pwdata[ccr_pkg::CMD_SEND];
      cmd.cancel_send     <= cmd_live & pwdata[ccr_pkg::CMD_CAN];
      cmd.release_rx_slot <= wr_cmd & pwdata[ccr_pkg::CMD_REL];
      cmd.clear_overrun   <= wr_cmd & pwdata[ccr_pkg::CMD_CLR];
      cmd.sleep_command   <= sleep_r;
      // sleep cannot be entered until the bus has been seen free
      if (reset_request_r)
        sleep_r <= 1'h0;
      else if (wr_cmd)
        sleep_r <= pwdata[ccr_pkg::CMD_SLP] & bus_on;
    end
  end

  // -------------------------------------------------------------
  // interrupt signals
  // -------------------------------------------------------------
  wire err_chg = (evt.err_status ^ err_prev_r) | (evt.bus_off ^ bo_prev_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq        <= '{default: 1'h0};
      err_prev_r <= 1'h0;
      bo_prev_r  <= 1'h0;
      ovr_prev_r <= 1'h0;
    end
    else
    begin
      err_prev_r <= evt.err_status;
      bo_prev_r  <= evt.bus_off;
      ovr_prev_r <= evt.overrun;
      irq.rx  <= ie_r[ccr_pkg::CTL_RX_EN-1] & evt.rx_ok;
      irq.tx  <= ie_r[ccr_pkg::CTL_TX_EN-1] & (evt.tx_done | evt.tx_buf_free);
      irq.err <= ie_r[ccr_pkg::CTL_ERR_EN-1] & err_chg;
      irq.ovr <= ie_r[ccr_pkg::CTL_OVR_EN-1] & evt.overrun & ~ovr_prev_r;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  a_cmd_reads_ones: assert property (@(posedge pclk) disable iff (!presetn)
    done && sel_cmd && !pwrite |-> prdata == ccr_pkg::CMD_READ)
    else $error("command read not all ones");

  a_bit5_one: assert property (@(posedge pclk) disable iff (!presetn)
    done && sel_ctrl && !pwrite |-> prdata[ccr_pkg::CTL_ONE] && prdata[31:8] == 24'h000000)
    else $error("control bit five not one");

  a_busoff_forces_req: assert property (@(posedge pclk) disable iff (!presetn)
    evt.bus_off |=> reset_request_r && reset_mode)
    else $error("bus-off did not force reset request");

  a_req_sync_edge: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(reset_request_r) && !$past(evt.bus_off) |-> $past(phase_r) && $past(pend_r))
    else $error("reset request changed off internal edge");

  a_req_abort_rewind: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(reset_request_r) |-> abort_xfer && wr_ptr == rd_ptr)
    else $error("reset entry without abort or rewind");

  a_rx_irq_cause: assert property (@(posedge pclk) disable iff (!presetn)
    irq.rx |-> $past(evt.rx_ok) && $past(ie_r[ccr_pkg::CTL_RX_EN-1]))
    else $error("receive interrupt without received message");

  a_ovr_irq_edge: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(evt.overrun) && ie_r[ccr_pkg::CTL_OVR_EN-1] |=> irq.ovr ##1 (!irq.ovr || $rose(evt.overrun)))
    else $error("overrun interrupt missing or stuck");

  a_err_on_busoff: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(evt.bus_off) && ie_r[ccr_pkg::CTL_ERR_EN-1] |=> irq.err)
    else $error("bus-off without error interrupt");

  a_one_free_exit: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ccr_pkg::ST_WAIT_FREE && !cause_busoff_r && free_pulse && !reset_request_r
    |=> bus_on)
    else $error("no bus-on after one bus-free period");

  a_busoff_128: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bus_on) && $past(cause_busoff_r) |-> $past(free_cnt_r) == 8'h7F)
    else $error("bus-on before 128 bus-free periods");

  a_ie_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ie_r == $past(pwdata[ccr_pkg::CTL_OVR_EN:ccr_pkg::CTL_RX_EN]))
    else $error("control write not stored");

endmodule : ccr_ctrl

/* File: tb/ccr_host.sv */
// Purpose: APB host model for the control/command register block
// Assumes: one transfer at a time, started by the bench
// Notes:   request held until pready is sampled high; released data inverted
`timescale 1ns/1ps

module ccr_host
(
  input  logic        pclk,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
  end

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {d[31:8], 1'b0, d[6:0]};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask : xfer
endmodule : ccr_host

/* File: tb/ccr_ctrl_bench.sv */
// Purpose: self-checking bench for the CAN control/command register block
// Assumes: ccr_host speaks APB; events and bit ticks driven here
// Notes:   bus-off exit needs 128 bus-free periods, which dominates run time
`timescale 1ns/1ps

`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_fail++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end

module ccr_ctrl_bench;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic               pready;
  logic               pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  ccr_pkg::ccr_evt_t  evt;
  ccr_pkg::ccr_cmd_t  cmd;
  ccr_pkg::ccr_irq_t  irq;
  logic [5:0]         msg_len;
  logic [5:0]         rd_ptr;
  logic [5:0]         wr_ptr;
  logic               bit_tick;
  logic               bus_level;
  logic               reset_mode;
  logic               abort_xfer;
  logic               bus_on;
  logic               rx_win_tx;
  logic [31:0]        q;
  logic               e;
  logic [4:0]         c;
  int                 n_fail;
  int                 n_tests;
  int                 n_abort;

  ccr_ctrl i_ccr_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .msg_len(msg_len), .bit_tick(bit_tick), .bus_level(bus_level), .cmd(cmd), .irq(irq),
    .reset_mode(reset_mode), .abort_xfer(abort_xfer), .bus_on(bus_on), .rx_win_tx(rx_win_tx),
    .rd_ptr(rd_ptr), .wr_ptr(wr_ptr));

  ccr_host i_ccr_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ------------------------------------------------------------
  // clock, watchdog, helpers
  // ------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("watchdog expired");
    summarize();
  end

  always @(posedge pclk)
    if (abort_xfer === 1'b1)
      n_abort++;

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic hw_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1;
  endtask : hw_reset

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic        re;
    i_ccr_host.xfer(1'b1, a, d, rq, re);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    i_ccr_host.xfer(1'b0, a, 32'h00000000, q, e);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      bit_tick <= 1'b1;
      @(posedge pclk);
      bit_tick <= 1'b0;
    end
    cyc(3);
  endtask : ticks

  // one-cycle event pulse, interrupt looked at one cycle later
  task automatic ev(input logic [6:0] v, input logic [3:0] ex);
    @(posedge pclk);
    evt <= v;
    @(posedge pclk);
    evt <= 7'h00;
    #1;
    `CHK("irq", ex, irq)
  endtask : ev

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    evt = 7'h00;
    msg_len = 6'h05;
    bit_tick = 1'b0;
    bus_level = 1'b1;
    n_fail = 0;
    n_tests = 0;
    n_abort = 0;
    hw_reset();
    `CHK("reset_mode", 1'b1, reset_mode)
    `CHK("pointers", 12'h000, {rd_ptr, wr_ptr})
    rd(ccr_pkg::ADDR_CTRL);
    `CHK("ctrl reset", 32'h00000021, q & 32'hFFFFFFBF)
    rd(ccr_pkg::ADDR_CMD);
    `CHK("cmd read", 32'h000000FF, q)
    rd(12'h008);
    `CHK("unmapped", 33'h100000000, {e, q})
    $display("test reset done");

    wr(ccr_pkg::ADDR_CTRL, 32'h000000DE);
    cyc(2);
    `CHK("req clear", 1'b0, reset_mode)
    rd(ccr_pkg::ADDR_CTRL);
    `CHK("ctrl rw", 32'h0000007E, q)
    ticks(10);
    `CHK("bus_on early", 1'b0, bus_on)
    ticks(1);
    `CHK("bus_on", 1'b1, bus_on)
    $display("test exit done");

    ev(7'h02, 4'h8);
    `CHK("wr_ptr", 6'h05, wr_ptr)
    ev(7'h01, 4'h0);
    `CHK("window tx", 1'b1, rx_win_tx)
    ev(7'h08, 4'h4);
    ev(7'h04, 4'h4);
    ev(7'h10, 4'h1);
    ev(7'h20, 4'h2);
    ev(7'h02, 4'h8);
    `CHK("window rx", 1'b0, rx_win_tx)
    wr(ccr_pkg::ADDR_CTRL, 32'h00000040);
    cyc(2);
    for (int i = 1; i < 6; i++)
      ev(7'h01 << i, 4'h0);
    $display("test events done");

    for (int i = 0; i < 5; i++)
    begin
      wr(ccr_pkg::ADDR_CMD, 32'h1 << i);
      #1;
      c = cmd;
      cyc(1);
      c = c | cmd;
      `CHK("cmd", 5'h10 >> i, c)
      cyc(2);
    end
    `CHK("release", 6'h05, rd_ptr)
    rd(ccr_pkg::ADDR_CMD);
    `CHK("cmd readback", 32'h000000FF, q)
    wr(ccr_pkg::ADDR_CMD, 32'h00000000);
    cyc(3);
    `CHK("wake", 5'h00, cmd)
    $display("test commands done");

    wr(ccr_pkg::ADDR_CTRL, 32'h00000041);
    // the request may land two cycles late; the abort pulse is counted one edge after it
    cyc(3);
    `CHK("req set", 1'b1, reset_mode)
    `CHK("abort", 1, n_abort)
    `CHK("rewind", 12'h145, {rd_ptr, wr_ptr})
    `CHK("bus_on off", 1'b0, bus_on)
    rd(ccr_pkg::ADDR_STATE);
    `CHK("state", 32'h00050500, q)
    rd(ccr_pkg::ADDR_CTRL);
    `CHK("bit6 sw", 32'h00000061, q)
    hw_reset();
    `CHK("hw ptrs", 12'h000, {rd_ptr, wr_ptr})
    rd(ccr_pkg::ADDR_CTRL);
    `CHK("bit6 hw", 32'h00000061, q)
    $display("test resets done");

    wr(ccr_pkg::ADDR_CTRL, 32'h00000048);
    cyc(2);
    ticks(11);
    `CHK("bus_on", 1'b1, bus_on)
    @(posedge pclk);
    evt <= 7'h40;
    @(posedge pclk);
    #1;
    `CHK("busoff irq", 4'h2, irq)
    cyc(2);
    `CHK("busoff req", 1'b1, reset_mode)
    @(posedge pclk);
    evt <= 7'h00;
    wr(ccr_pkg::ADDR_CTRL, 32'h00000048);
    cyc(2);
    rd(ccr_pkg::ADDR_CTRL);
    `CHK("req readback", 32'h00000068, q)
    ticks(11 * 127);
    `CHK("bus_on 127", 1'b0, bus_on)
    ticks(11);
    `CHK("bus_on 128", 1'b1, bus_on)
    $display("test bus-off done");
    summarize();
  end
endmodule : ccr_ctrl_bench
